// *** rtl/tsc_defines.svh ***
// Constants of the signalling message codec: register offsets, field positions,
// reset values and heading codes. Assumes inclusion by bare name from rtl/.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
// Register byte offsets (one 32-bit word each, eight words for each status field)
`define TSC_OFS_CTRL        8'h00
`define TSC_OFS_TX_HEAD     8'h04
`define TSC_OFS_RX_HEAD     8'h08
`define TSC_OFS_RX_INFO     8'h0C
`define TSC_OFS_RX_CIC      8'h10
`define TSC_OFS_TX_STAT     8'h20
`define TSC_OFS_RX_STAT     8'h40
`define TSC_STAT_REGION     8'hE0
// Control and status bit positions
`define TSC_CTRL_SEND       0
`define TSC_CTRL_DONE       1
`define TSC_CTRL_UNREC      2
// Reset value of all state
`define TSC_RST_STATE       '0
// First heading codes
`define TSC_H0_CHARGE       4'h4
`define TSC_H0_UNSUCC       4'h5
`define TSC_H0_CALL_SUP     4'h6
`define TSC_H0_CIRC_SUP     4'h7
`define TSC_H0_GROUP        4'h8
// Second heading codes and limits
`define TSC_H1_ADDR_CPL     4'h1
`define TSC_H1_CHARGE       4'h2
`define TSC_H1_UNSUCC_LAST  4'hC
`define TSC_H1_EXTENDED     4'hF
`define TSC_IND_SUBS_BUSY   4'h1
`define TSC_H1_CALL_LAST    4'h7
`define TSC_H1_CIRC_LAST    4'h7
`define TSC_H1_SPARE_ZERO   4'h0
// Circuit group supervision second headings
`define TSC_MAINT_GROUP_BLOCK_MSG       4'h1
`define TSC_MAINT_GROUP_BLOCK_ACK_MSG   4'h2
`define TSC_MAINT_GROUP_UNBLOCK_MSG     4'h3
`define TSC_MAINT_GROUP_UNBLOCK_ACK_MSG 4'h4
`define TSC_HW_GROUP_BLOCK_MSG          4'h5
`define TSC_HW_GROUP_BLOCK_ACK_MSG      4'h6
`define TSC_HW_GROUP_UNBLOCK_MSG        4'h7
`define TSC_HW_GROUP_UNBLOCK_ACK_MSG    4'h8
`define TSC_GROUP_RESET_MSG             4'h9
`define TSC_GROUP_RESET_ACK_MSG         4'hA
`define TSC_SW_GROUP_BLOCK_MSG          4'hB
`define TSC_SW_GROUP_BLOCK_ACK_MSG      4'hC
`define TSC_SW_GROUP_UNBLOCK_MSG        4'hD
`define TSC_SW_GROUP_UNBLOCK_ACK_MSG    4'hE
`endif

// *** rtl/tsc_pkg.sv ***
// Types of the signalling message codec: states, classes and the state record.
// Assumes nothing of its surroundings.
package tsc_pkg;
    typedef enum logic [2:0] {T_IDLE, T_HEAD, T_IND, T_PC0, T_PC1, T_RNG, T_STAT} tsc_tx_e;
    typedef enum logic [2:0] {R_HEAD, R_IND, R_PC0, R_PC1, R_RNG, R_STAT, R_SKIP} tsc_rx_e;
    typedef enum logic [2:0] {C_OTHER, C_CHARGE, C_UNSUCC, C_UNSUCC_EXT, C_CALL_SUP, C_CIRC_SUP, C_GROUP} tsc_cls_e;
    typedef enum logic [2:0] {G_NONE, G_BLOCK, G_BLOCK_ACK, G_UNBLOCK, G_UNBLOCK_ACK, G_RESET, G_RESET_ACK} tsc_grp_e;
    typedef struct packed {
        logic         ack;
        logic [31:0]  rdat;
        logic [3:0]   tx_h0;
        logic [3:0]   tx_h1;
        logic [7:0]   tx_aux;
        logic [15:0]  tx_pc;
        logic [255:0] tx_stat;
        tsc_tx_e      tx_st;
        logic [5:0]   tx_idx;
        logic [7:0]   tx_byte;
        logic         tx_last;
        tsc_rx_e      rx_st;
        logic [5:0]   rx_idx;
        logic [3:0]   rx_h0;
        logic [3:0]   rx_h1;
        logic [7:0]   rx_aux;
        logic [15:0]  rx_pc;
        logic [15:0]  rx_cic;
        logic [255:0] rx_stat;
        logic         rx_done;
        logic         rx_unrec;
        tsc_cls_e     rx_cls;
    } tsc_state_s;
endpackage

// *** rtl/tsc_codec.sv ***
// Signalling message codec: builds heading, indicator, point code, range and status
// octets on a byte stream, and decodes the same from a received byte stream.
// Assumes the label is handled outside; the receive circuit code arrives on a port.
// Summary of operation
// R01: Charging message heading is first 0100, second 0010; charging field layout national.
// R02: First heading 0101 is simple unsuccessful; second 0001..1100 causes, others spare.
// R03: Second 1111 adds indicator octet; low nibble 0001 subscriber busy, rest spare.
// R04: Extended unsuccessful message carries originating point code after the indicator.
// R05: Call supervision 0110: answers 0000..0010, clear-back, clear-forward, re-answer 0011..0101.
// R06: Call supervision 0110 forward-transfer, 0111 calling-party clear, 1000..1111 spare.
// R07: Circuit supervision 0111: 0001..0111 signals, 0000 and 1000..1111 spare.
// R08: Circuit group supervision uses first heading 1000; seconds 0000, 1111 spare.
// R09: Group 0001..0100: maintenance block, its ack, unblock, its ack.
// R10: Group 0101..1000: hardware-failure block, its ack, unblock, its ack.
// R11: Group 1001 is circuit group reset, 1010 its acknowledgement.
// R12: Group 1011..1110: software block, its ack, unblock, its ack.
// R13: Nonzero range: label circuit code is the first circuit handled.
// R14: Zero range: representative circuit of predetermined group, no status field.
// R15: Circuits handled equal range plus one, 2 up to 256.
// R16: All group messages but reset carry status field of range+1 bits.
// R17: First status bit is the label circuit, following bits consecutive circuits.
// R18: Last circuit equals label circuit code plus range.
// R19: Transmitter pads status field to whole octets with zero bits.
// R20: Block/unblock status bit 1 asserts action for circuit, 0 no action.
// R21: Reset acknowledgement status bit 1 means maintenance blocked, 0 not.
// R22: Receiver flags spare heading or indicator codes as unrecognised.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_codec #(
    parameter int PC_W  = 14,
    parameter int CIC_W = 12
) (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 srst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Transmit octet stream
    output logic      [7:0]           tx_data_o,
    output logic                      tx_valid_o,
    output logic                      tx_last_o,
    input  wire logic                 tx_ready_i,
    // Receive octet stream
    input  wire logic [7:0]           rx_data_i,
    input  wire logic                 rx_valid_i,
    input  wire logic                 rx_last_i,
    input  wire logic [CIC_W-1:0]     rx_cic_i,
    output logic                      rx_ready_o,
    // Receive status
    output logic                      rx_done_o,
    output logic                      rx_unrec_o
);

    // Point code must span two octets; circuit codes fit the 16-bit field
    if (PC_W < 9 || PC_W > 16 || CIC_W < 1 || CIC_W > 16) begin : g_bad_param
        $error("tsc_codec: PC_W must be 9..16 and CIC_W 1..16");
    end

    tsc_pkg::tsc_state_s s_r;
    tsc_pkg::tsc_state_s s_nxt;
    logic                req;
    logic                wr;
    logic                send;
    logic                tx_ext;
    logic                tx_grp;
    logic [7:0]          pc_hi_mask;
    logic [15:0]         cic_mask;
    logic [7:0]          stat_oct;
    logic [7:0]          pad_mask;
    logic [8:0]          rx_count;
    logic [15:0]         rx_last_cic;
    tsc_pkg::tsc_grp_e   rx_grp;

    // Merge write data under byte enables
    function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Spare headings and indicators are flagged, never acted on
    function automatic logic spare_f(input logic [3:0] h0, input logic [3:0] h1, input logic [7:0] aux);
        case (h0)
            `TSC_H0_CHARGE:   spare_f = (h1 != `TSC_H1_CHARGE) && (h1 != `TSC_H1_ADDR_CPL);   // [R01] [R22]
            `TSC_H0_UNSUCC:   spare_f = (h1 == `TSC_H1_EXTENDED) ? (aux[3:0] != `TSC_IND_SUBS_BUSY)   // [R03]
                                      : (h1 == `TSC_H1_SPARE_ZERO) || (h1 > `TSC_H1_UNSUCC_LAST);   // [R02]
            `TSC_H0_CALL_SUP: spare_f = (h1 > `TSC_H1_CALL_LAST);                                // [R05] [R06]
            `TSC_H0_CIRC_SUP: spare_f = (h1 == `TSC_H1_SPARE_ZERO) || (h1 > `TSC_H1_CIRC_LAST);  // [R07]
            `TSC_H0_GROUP:    spare_f = (h1 == `TSC_H1_SPARE_ZERO) || (h1 == `TSC_H1_EXTENDED);  // [R08]
            default:          spare_f = 1'b0;
        endcase
    endfunction

    // Message family from the headings
    function automatic tsc_pkg::tsc_cls_e class_f(input logic [3:0] h0, input logic [3:0] h1);
        case (h0)
            `TSC_H0_CHARGE:   class_f = (h1 == `TSC_H1_CHARGE) ? tsc_pkg::C_CHARGE : tsc_pkg::C_OTHER;  // [R01]
            `TSC_H0_UNSUCC:   class_f = (h1 == `TSC_H1_EXTENDED) ? tsc_pkg::C_UNSUCC_EXT : tsc_pkg::C_UNSUCC;
            `TSC_H0_CALL_SUP: class_f = tsc_pkg::C_CALL_SUP;
            `TSC_H0_CIRC_SUP: class_f = tsc_pkg::C_CIRC_SUP;
            `TSC_H0_GROUP:    class_f = tsc_pkg::C_GROUP;
            default:          class_f = tsc_pkg::C_OTHER;
        endcase
    endfunction

    // Group action from the second heading; status bits then mean that action
    function automatic tsc_pkg::tsc_grp_e grp_f(input logic [3:0] h1);
        case (h1)
            `TSC_MAINT_GROUP_BLOCK_MSG, `TSC_HW_GROUP_BLOCK_MSG,
            `TSC_SW_GROUP_BLOCK_MSG:                grp_f = tsc_pkg::G_BLOCK;          // [R09] [R10] [R12] [R20]
            `TSC_MAINT_GROUP_BLOCK_ACK_MSG, `TSC_HW_GROUP_BLOCK_ACK_MSG,
            `TSC_SW_GROUP_BLOCK_ACK_MSG:            grp_f = tsc_pkg::G_BLOCK_ACK;      // [R09] [R10] [R12] [R20]
            `TSC_MAINT_GROUP_UNBLOCK_MSG, `TSC_HW_GROUP_UNBLOCK_MSG,
            `TSC_SW_GROUP_UNBLOCK_MSG:              grp_f = tsc_pkg::G_UNBLOCK;        // [R09] [R10] [R12] [R20]
            `TSC_MAINT_GROUP_UNBLOCK_ACK_MSG, `TSC_HW_GROUP_UNBLOCK_ACK_MSG,
            `TSC_SW_GROUP_UNBLOCK_ACK_MSG:          grp_f = tsc_pkg::G_UNBLOCK_ACK;    // [R09] [R10] [R12] [R20]
            `TSC_GROUP_RESET_MSG:                   grp_f = tsc_pkg::G_RESET;          // [R11]
            `TSC_GROUP_RESET_ACK_MSG:               grp_f = tsc_pkg::G_RESET_ACK;      // [R11] [R21]
            default:                                grp_f = tsc_pkg::G_NONE;
        endcase
    endfunction

    // Bus request decode; the ack flop gives one wait state and blocks a double take
    assign req      = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wr       = req & wb_we_i;
    assign send     = wr && (wb_adr_i == `TSC_OFS_CTRL) && wb_sel_i[0] && wb_dat_i[`TSC_CTRL_SEND];
    assign tx_ext   = (s_r.tx_h0 == `TSC_H0_UNSUCC) && (s_r.tx_h1 == `TSC_H1_EXTENDED);
    assign tx_grp   = (s_r.tx_h0 == `TSC_H0_GROUP);
    assign pc_hi_mask = 8'((9'h001 << (PC_W - 8)) - 9'h001);
    assign cic_mask   = 16'((17'h00001 << CIC_W) - 17'h00001);
    assign stat_oct   = s_r.tx_stat[{s_r.tx_idx[4:0], 3'h0} +: 8];

    // Receive summary: circuit count and last circuit of the group
    assign rx_count    = (s_r.rx_h0 == `TSC_H0_GROUP && s_r.rx_aux != 8'h00) ? 9'(s_r.rx_aux) + 9'h001 : 9'h000;  // [R15]
    assign rx_last_cic = (s_r.rx_cic + 16'(s_r.rx_aux)) & cic_mask;   // [R18]
    assign rx_grp      = (s_r.rx_h0 == `TSC_H0_GROUP) ? grp_f(s_r.rx_h1) : tsc_pkg::G_NONE;

    // Bits past the last circuit of the final status octet are forced to zero
    for (genvar g = 0; g < 8; g++) begin : g_pad
        assign pad_mask[g] = ({s_r.tx_idx[4:0], 3'(g)} <= s_r.tx_aux);   // [R16] [R19]
    end

    // Next-state logic: bus, transmit builder, receive decoder
    always_comb begin
        logic short_frame;
        short_frame = 1'b0;
        s_nxt       = s_r;
        s_nxt.ack   = req;
        // Register reads
        if (req) begin
            if ((wb_adr_i & `TSC_STAT_REGION) == `TSC_OFS_TX_STAT) begin
                s_nxt.rdat = s_r.tx_stat[{wb_adr_i[4:2], 5'h00} +: 32];
            end else if ((wb_adr_i & `TSC_STAT_REGION) == `TSC_OFS_RX_STAT) begin
                s_nxt.rdat = s_r.rx_stat[{wb_adr_i[4:2], 5'h00} +: 32];   // [R17]
            end else begin
                case (wb_adr_i)
                    `TSC_OFS_CTRL:    s_nxt.rdat = {29'h0, s_r.rx_unrec, s_r.rx_done, s_r.tx_st != tsc_pkg::T_IDLE};
                    `TSC_OFS_TX_HEAD: s_nxt.rdat = {s_r.tx_pc, s_r.tx_aux, s_r.tx_h1, s_r.tx_h0};
                    `TSC_OFS_RX_HEAD: s_nxt.rdat = {s_r.rx_pc, s_r.rx_aux, s_r.rx_h1, s_r.rx_h0};
                    `TSC_OFS_RX_INFO: s_nxt.rdat = {7'h0, rx_count, 8'h0, 1'b0, rx_grp, 1'b0, s_r.rx_cls};
                    `TSC_OFS_RX_CIC:  s_nxt.rdat = {rx_last_cic, s_r.rx_cic};   // [R13] [R18]
                    default:          s_nxt.rdat = 32'h0000_0000;
                endcase
            end
        end
        // Register writes; message contents are frozen while a frame is going out
        if (wr && s_r.tx_st == tsc_pkg::T_IDLE) begin
            if (wb_adr_i == `TSC_OFS_TX_HEAD) begin
                {s_nxt.tx_pc, s_nxt.tx_aux, s_nxt.tx_h1, s_nxt.tx_h0} =
                    merge_f({s_r.tx_pc, s_r.tx_aux, s_r.tx_h1, s_r.tx_h0}, wb_dat_i, wb_sel_i);
            end
            if ((wb_adr_i & `TSC_STAT_REGION) == `TSC_OFS_TX_STAT) begin
                s_nxt.tx_stat[{wb_adr_i[4:2], 5'h00} +: 32] =
                    merge_f(s_r.tx_stat[{wb_adr_i[4:2], 5'h00} +: 32], wb_dat_i, wb_sel_i);
            end
        end
        if (wr && wb_adr_i == `TSC_OFS_CTRL && wb_sel_i[0] && wb_dat_i[`TSC_CTRL_DONE]) begin
            s_nxt.rx_done = 1'b0;
        end
        // Transmit: heading octet first, H0 in the low nibble
        if (s_r.tx_st == tsc_pkg::T_IDLE) begin
            if (send) begin
                s_nxt.tx_st   = tsc_pkg::T_HEAD;
                s_nxt.tx_byte = {s_r.tx_h1, s_r.tx_h0};   // [R01] [R02] [R05] [R07] [R08]
                s_nxt.tx_last = !tx_ext && !tx_grp;
                s_nxt.tx_idx  = 6'h00;
            end
        end else if (tx_ready_i) begin
            if (s_r.tx_last) begin
                s_nxt.tx_st   = tsc_pkg::T_IDLE;
                s_nxt.tx_last = 1'b0;
            end else begin
                unique case (s_r.tx_st)
                    tsc_pkg::T_HEAD: begin
                        s_nxt.tx_byte = s_r.tx_aux;
                        if (tx_ext) begin
                            s_nxt.tx_st   = tsc_pkg::T_IND;   // [R03]
                            s_nxt.tx_last = 1'b0;
                        end else begin
                            s_nxt.tx_st   = tsc_pkg::T_RNG;
                            s_nxt.tx_last = (s_r.tx_aux == 8'h00) || (s_r.tx_h1 == `TSC_GROUP_RESET_MSG);  // [R14] [R16]
                        end
                    end
                    tsc_pkg::T_IND: begin
                        s_nxt.tx_st   = tsc_pkg::T_PC0;
                        s_nxt.tx_byte = s_r.tx_pc[7:0];   // [R04]
                    end
                    tsc_pkg::T_PC0: begin
                        s_nxt.tx_st   = tsc_pkg::T_PC1;
                        s_nxt.tx_byte = s_r.tx_pc[15:8] & pc_hi_mask;   // [R04]
                        s_nxt.tx_last = 1'b1;
                    end
                    tsc_pkg::T_RNG, tsc_pkg::T_STAT: begin
                        // Octet count is range/8 + 1, so the last index is range[7:3]
                        s_nxt.tx_st   = tsc_pkg::T_STAT;
                        s_nxt.tx_byte = stat_oct & pad_mask;   // [R17] [R19]
                        s_nxt.tx_last = (s_r.tx_idx[4:0] == s_r.tx_aux[7:3]);   // [R15] [R16]
                        s_nxt.tx_idx  = s_r.tx_idx + 6'h01;
                    end
                    tsc_pkg::T_PC1, tsc_pkg::T_IDLE: begin
                        s_nxt.tx_st = tsc_pkg::T_IDLE;
                    end
                endcase
            end
        end
        // Receive: always ready; octets past the expected fields are skipped
        if (rx_valid_i) begin
            unique case (s_r.rx_st)
                tsc_pkg::R_HEAD: begin
                    s_nxt.rx_h0   = rx_data_i[3:0];
                    s_nxt.rx_h1   = rx_data_i[7:4];
                    s_nxt.rx_cic  = 16'(rx_cic_i);   // [R13]
                    s_nxt.rx_aux  = 8'h00;
                    s_nxt.rx_pc   = 16'h0000;
                    s_nxt.rx_stat = '0;
                    s_nxt.rx_idx  = 6'h00;
                    if (rx_data_i[3:0] == `TSC_H0_UNSUCC && rx_data_i[7:4] == `TSC_H1_EXTENDED) begin
                        s_nxt.rx_st = tsc_pkg::R_IND;   // [R03]
                    end else if (rx_data_i[3:0] == `TSC_H0_GROUP) begin
                        s_nxt.rx_st = tsc_pkg::R_RNG;   // [R08]
                    end else begin
                        s_nxt.rx_st = tsc_pkg::R_SKIP;
                    end
                end
                tsc_pkg::R_IND: begin
                    s_nxt.rx_aux = rx_data_i;
                    s_nxt.rx_st  = tsc_pkg::R_PC0;
                end
                tsc_pkg::R_PC0: begin
                    s_nxt.rx_pc[7:0] = rx_data_i;   // [R04]
                    s_nxt.rx_st      = tsc_pkg::R_PC1;
                end
                tsc_pkg::R_PC1: begin
                    s_nxt.rx_pc[15:8] = rx_data_i & pc_hi_mask;
                    s_nxt.rx_st       = tsc_pkg::R_SKIP;
                end
                tsc_pkg::R_RNG: begin
                    s_nxt.rx_aux = rx_data_i;
                    s_nxt.rx_st  = (rx_data_i == 8'h00 || s_r.rx_h1 == `TSC_GROUP_RESET_MSG)
                                 ? tsc_pkg::R_SKIP : tsc_pkg::R_STAT;   // [R14] [R16]
                end
                tsc_pkg::R_STAT: begin
                    s_nxt.rx_stat[{s_r.rx_idx[4:0], 3'h0} +: 8] = rx_data_i;   // [R17] [R20] [R21]
                    s_nxt.rx_idx = s_r.rx_idx + 6'h01;
                    if (s_r.rx_idx[4:0] == s_r.rx_aux[7:3]) begin
                        s_nxt.rx_st = tsc_pkg::R_SKIP;
                    end
                end
                tsc_pkg::R_SKIP: begin
                    s_nxt.rx_st = tsc_pkg::R_SKIP;
                end
            endcase
            // Frame end: a frame cut short is as unusable as a spare code
            if (rx_last_i) begin
                short_frame    = (s_nxt.rx_st != tsc_pkg::R_SKIP);
                s_nxt.rx_st    = tsc_pkg::R_HEAD;
                s_nxt.rx_done  = 1'b1;   // Set wins over a clear in the same cycle
                s_nxt.rx_unrec = spare_f(s_nxt.rx_h0, s_nxt.rx_h1, s_nxt.rx_aux) | short_frame;   // [R22]
                s_nxt.rx_cls   = class_f(s_nxt.rx_h0, s_nxt.rx_h1);
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            s_r <= `TSC_RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; valid is decoded from state so it drops the cycle after the last octet is taken
    assign wb_ack_o   = s_r.ack;
    assign wb_dat_o   = s_r.rdat;
    assign tx_data_o  = s_r.tx_byte;
    assign tx_valid_o = (s_r.tx_st != tsc_pkg::T_IDLE);
    assign tx_last_o  = s_r.tx_last;
    assign rx_ready_o = 1'b1;
    assign rx_done_o  = s_r.rx_done;
    assign rx_unrec_o = s_r.rx_unrec;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sequence ext_head_taken_s;
        tx_valid_o && tx_ready_i && s_r.tx_st == tsc_pkg::T_HEAD && tx_ext;
    endsequence
    sequence ext_tail_s;
        // The sink may stall for any time, so the low point code octet is awaited in a bounded window
        s_r.tx_st == tsc_pkg::T_IND && !tx_last_o ##[1:1000]
        s_r.tx_st == tsc_pkg::T_PC0 && tx_data_o == s_r.tx_pc[7:0];
    endsequence

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    head_octet_a: assert property (send && !tx_valid_o |=> tx_valid_o && tx_data_o == {s_r.tx_h1, s_r.tx_h0})   // [R01]
        else $error("heading octet wrong");
    ext_pc_a: assert property (ext_head_taken_s |=> ext_tail_s)   // [R04]
        else $error("point code does not follow indicator");
    zero_range_a: assert property (s_r.tx_st == tsc_pkg::T_RNG && s_r.tx_aux == 8'h00 |-> tx_last_o)   // [R14]
        else $error("status field sent with zero range");
    pad_zero_a: assert property (s_r.tx_st == tsc_pkg::T_STAT && tx_last_o
        |-> ({1'b0, tx_data_o} >> ({1'b0, s_r.tx_aux[2:0]} + 4'h1)) == 9'h000)   // [R19]
        else $error("pad bits not zero");
    reset_no_stat_a: assert property (rx_valid_i && s_r.rx_st == tsc_pkg::R_RNG
        && s_r.rx_h1 == `TSC_GROUP_RESET_MSG |=> s_r.rx_st != tsc_pkg::R_STAT)   // [R16]
        else $error("group reset took a status field");
    spare_call_a: assert property (rx_valid_i && rx_last_i && s_r.rx_st == tsc_pkg::R_HEAD
        && rx_data_i[3:0] == `TSC_H0_CALL_SUP && rx_data_i[7] |=> rx_unrec_o && rx_done_o)   // [R22]
        else $error("spare call supervision code not flagged");
    done_set_wins_a: assert property (rx_valid_i && rx_last_i |=> rx_done_o [*1] ##0 s_r.rx_st == tsc_pkg::R_HEAD)
        else $error("frame end lost against a clear");

endmodule // tsc_codec

// *** sim/tsc_peer.sv ***
// Peer exchange model: takes octets from the transmit stream and returns each one
// on the receive stream a cycle later. Assumes one clock shared with the codec.
`timescale 1ns/1ps
module tsc_peer (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    // Octets from the codec
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o,
    // Octets back to the codec
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_last_o
);
    // Stall every other cycle; idle data is inverted so a stale octet never passes
    always_ff @(posedge sys_clk_i) begin
        tx_ready_o <= !srst_i && !tx_ready_o;
        rx_valid_o <= !srst_i && tx_valid_i && tx_ready_o;
        rx_last_o  <= !srst_i && tx_valid_i && tx_ready_o && tx_last_i;
        rx_data_o  <= (tx_valid_i && tx_ready_o) ? tx_data_i : ~rx_data_o;
    end
endmodule // tsc_peer

// *** sim/test_telephony_supervision_message_codec.sv ***
// Bench for the codec: frames sent go round the peer model and come back through
// the receive registers. Assumes tsc_codec and tsc_peer on one 50 MHz clock.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module test_telephony_supervision_message_codec;
    logic        sys_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic        cyc       = 1'b0;
    logic        we        = 1'b0;
    logic [7:0]  adr       = 8'h00;
    logic [31:0] wdat      = 32'h0;
    logic [11:0] circuit_ident_code       = 12'hF80;
    logic [31:0] rdat, r;
    logic [7:0]  td, rd;
    logic        ack, tv, tl, tr, rv, rl, rdy, done, unrec;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    int          h, k;
    tsc_codec dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_o(td),
        .tx_valid_o(tv), .tx_last_o(tl), .tx_ready_i(tr), .rx_data_i(rd), .rx_valid_i(rv), .rx_last_i(rl),
        .rx_cic_i(circuit_ident_code), .rx_ready_o(rdy), .rx_done_o(done), .rx_unrec_o(unrec));
    tsc_peer peer (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .tx_data_i(td), .tx_valid_i(tv), .tx_last_i(tl),
        .tx_ready_o(tr), .rx_data_o(rd), .rx_valid_o(rv), .rx_last_o(rl));
    // Free-running clock
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle; ack is read before the edge's own updates land
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk_i);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
        if (i == 50) begin
            chk("ack wait", 1, 0);
            end_of_test();
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e & m, q & m);
    endtask
    // Send one frame, poll until received, eu = {unrecognised, class}
    task automatic frame(input logic [31:0] hd, input logic [3:0] eu);
        logic [31:0] q;
        int i;
        wb(1'b1, `TSC_OFS_TX_HEAD, hd, q);
        wb(1'b1, `TSC_OFS_CTRL, 32'h3, q);
        // Read data of the send write still shows the previous frame's done flag
        q = 32'h0;
        for (i = 0; i < 500 && q[1] !== 1'b1; i++) wb(1'b0, `TSC_OFS_CTRL, 32'h0, q);
        chk("done", 1, q[1]);
        if (i == 500) end_of_test();
        chk("unrec pin", eu[3], unrec);
        chk("done pin", 1, done);
        chk("rx ready", 1, rdy);
        chk("unrec", eu[3], q[2]);
        if (!eu[3]) rchk("class", `TSC_OFS_RX_INFO, eu[2:0], 32'h7);
        $display("frame %h ended", hd);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rchk("ctrl", `TSC_OFS_CTRL, 32'h0, '1);
        rchk("tx head", `TSC_OFS_TX_HEAD, 32'h0, '1);
        rchk("unmapped", 8'hF0, 32'h0, '1);
        frame(32'h24, 4'h1);
        frame(32'h15, 4'h2);
        frame(32'hC5, 4'h2);
        frame(32'h05, 4'h8);
        frame(32'hD5, 4'h8);
        frame(32'hFFFF_F1F5, 4'h3);
        rchk("ext head", `TSC_OFS_RX_HEAD, 32'h3FFF_F1F5, '1);
        frame(32'h02F5, 4'h8);
        frame(32'h06, 4'h4);
        frame(32'h56, 4'h4);
        frame(32'h76, 4'h4);
        frame(32'h86, 4'h8);
        frame(32'h17, 4'h5);
        frame(32'h77, 4'h5);
        frame(32'h07, 4'h8);
        frame(32'h87, 4'h8);
        frame(32'h08, 4'h8);
        frame(32'hF8, 4'h8);
        frame(32'hB8, 4'h6);
        rchk("zero range", `TSC_OFS_RX_INFO, 32'h16, 32'h01FF_0077);
        wb(1'b1, `TSC_OFS_TX_STAT, 32'hA5, r);
        for (h = 1; h < 15; h++) begin
            frame({16'h0, 8'h03, h[3:0], 4'h8}, 4'h6);
            k = (h == 9) ? 5 : (h == 10) ? 6 : ((h > 10 ? h - 11 : h - 1) % 4) + 1;
            rchk("kind", `TSC_OFS_RX_INFO, 32'h0004_0006 | (k << 4), 32'h01FF_0077);
            rchk("cic", `TSC_OFS_RX_CIC, 32'h0F83_0F80, '1);
            if (h != 9) rchk("stat pad", `TSC_OFS_RX_STAT, 32'h05, 32'hFF);
        end
        for (h = 0; h < 8; h++) wb(1'b1, `TSC_OFS_TX_STAT + 8'(4 * h), 32'h1357_9BDF ^ h, r);
        rchk("tx stat", `TSC_OFS_TX_STAT + 8'h1C, 32'h1357_9BDF ^ 7, '1);
        frame(32'hFF18, 4'h6);
        rchk("circuits", `TSC_OFS_RX_INFO, 32'h0100_0016, 32'h01FF_0077);
        rchk("last cic", `TSC_OFS_RX_CIC, 32'h007F_0F80, '1);
        for (h = 0; h < 8; h++) rchk("stat", `TSC_OFS_RX_STAT + 8'(4 * h), 32'h1357_9BDF ^ h, '1);
        end_of_test();
    end
endmodule // test_telephony_supervision_message_codec
